// ==== design/buck2_pkg.sv ====
// Package for the second buck converter control block.
// Assumes a 32-bit APB slave at 200 MHz; registers are word aligned.
package buck2_pkg;
   // Printed offsets are register indices; byte address is four times it
   localparam logic [15:0] IDX_FAULT_CTRL = 16'h405C;
   localparam logic [15:0] IDX_RUN_CFG    = 16'h405D;
   localparam logic [15:0] IDX_SLEEP_CODE = 16'h405E;
   localparam logic [15:0] IDX_IRQ_STAT   = 16'h4060;
   localparam logic [15:0] IDX_IRQ_CLR    = 16'h4061;
   localparam logic [15:0] IDX_IRQ_ENA    = 16'h4062;
   localparam logic [15:0] IDX_HW_STATUS  = 16'h4063;
   localparam logic [15:0] IDX_OTP_CODE   = 16'h4064;
   // Field positions, fault/override register
   localparam int ACT_LSB   = 14;
   localparam int SRC_LSB   = 11;
   localparam int VCH_BIT   = 10;
   localparam int OBEH_LSB  = 8;
   localparam int THR_LSB   = 4;
   localparam int DET_BIT   = 0;
   // Field positions, run config register
   localparam int SLOT_LSB  = 13;
   localparam int RBEH_LSB  = 8;
   localparam int VHI_LSB   = 2;
   // Reset values and write masks of the two documented registers
   localparam logic [15:0] FAULT_CTRL_RST = 16'h0300;
   localparam logic [15:0] RUN_CFG_RST    = 16'h0100;
   localparam logic [15:0] FAULT_CTRL_WMASK = 16'hDF71;
   localparam logic [15:0] RUN_CFG_WMASK    = 16'hE37F;
   // Undervoltage action codes
   localparam logic [1:0] ACT_IGNORE = 2'h0;
   localparam logic [1:0] ACT_OFF    = 2'h1;
   localparam logic [1:0] ACT_RESET  = 2'h2;
   // Behaviour codes
   localparam logic [1:0] BEH_FCCM   = 2'h0;
   localparam logic [1:0] BEH_AUTO   = 2'h1;
   localparam logic [1:0] BEH_LDO    = 2'h2;
   localparam logic [1:0] BEH_HYST   = 2'h3;
   // Start slot codes
   localparam logic [2:0] SLOT_NEVER = 3'h0;
   localparam logic [2:0] SLOT_LAST  = 3'h5;
   localparam logic [2:0] SLOT_HWEN1 = 3'h6;
   localparam logic [2:0] SLOT_HWEN2 = 3'h7;
   // Voltage coding
   localparam logic [6:0] VCODE_MIN  = 7'h08;
   localparam logic [6:0] VCODE_MAX  = 7'h68;
   localparam logic [6:0] VCODE_4MHZ = 7'h48;
   localparam int         STEP_UV    = 12500;
   localparam int         BASE_UV    = 600000;
   localparam int         THR_STEP_MA = 250;
   // Interrupt bit positions and status width
   localparam int IRQ_UV  = 0;
   localparam int IRQ_HC  = 1;
   localparam int IRQ_W   = 2;
endpackage

// ==== design/buck2_code_sat.sv ====
// Voltage code saturation and millivolt-free target code for the stage.
// Assumes a combinational use inside the clocked control block.
`timescale 1ns/1ps
`default_nettype none
module buck2_code_sat
   import buck2_pkg::*;
(
   input  wire logic [6:0] code_in,
   output logic      [6:0] code_out
);
   // Low codes pin at the minimum, high codes at the maximum step
   assign code_out = (code_in <= VCODE_MIN) ? VCODE_MIN :
                     (code_in >= VCODE_MAX) ? VCODE_MAX : code_in;
endmodule // buck2_code_sat
`default_nettype wire

// ==== design/buck2_ctrl.sv ====
// Control registers and override logic for the second buck converter.
// Assumes APB master on clk, hardware pins asynchronous to clk, and an
// analog stage that reads the applied code, behaviour and enable levels.
`timescale 1ns/1ps
`default_nettype none
module buck2_ctrl
   import buck2_pkg::*;
#(
   parameter int SLOTS = 5
)
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        otp_load,
   input  wire logic [4:0]  otp_code_hi,
   input  wire logic [2:0]  seq_slot,
   input  wire logic        seq_up,
   input  wire logic        hw_ctrl1,
   input  wire logic        hw_ctrl2,
   input  wire logic        hw_en1,
   input  wire logic        hw_en2,
   input  wire logic        undervolt,
   input  wire logic        high_current,
   input  wire logic        freq_4mhz,
   output logic             conv_enable,
   output logic      [1:0]  conv_behaviour,
   output logic      [6:0]  conv_code,
   output logic      [2:0]  hc_threshold,
   output logic             hc_detect_on,
   output logic             device_reset_req,
   output logic             irq
);
   logic [15:0] fault_ctrl_ff;
   logic [15:0] run_cfg_ff;
   logic [6:0]  sleep_code_ff;
   logic [IRQ_W-1:0] irq_stat_ff;
   logic [IRQ_W-1:0] irq_ena_ff;
   logic [3:0]  sync1_ff;
   logic [3:0]  sync2_ff;
   logic [1:0]  ev1_ff;
   logic [1:0]  ev2_ff;
   logic [1:0]  ev3_ff;
   logic        uv_off_ff;
   logic        slot_on_ff;
   logic        code_over_ff;
   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        pslverr_ff;
   logic        conv_enable_ff;
   logic [1:0]  conv_beh_ff;
   logic [6:0]  conv_code_ff;
   logic        dev_rst_ff;
   logic        irq_ff;

   // Byte address to register index; low two bits must be zero
   function automatic logic hit(input logic [31:0] a, input logic [15:0] i);
      return (a[1:0] == 2'h0) && (a[31:2] == {14'h0, i});
   endfunction

   wire setup    = psel && !penable;
   wire wr_take  = psel && penable && pwrite && pready_ff && ce;
   wire sel_fc   = hit(paddr, IDX_FAULT_CTRL);
   wire sel_rc   = hit(paddr, IDX_RUN_CFG);
   wire sel_sc   = hit(paddr, IDX_SLEEP_CODE);
   wire sel_st   = hit(paddr, IDX_IRQ_STAT);
   wire sel_cl   = hit(paddr, IDX_IRQ_CLR);
   wire sel_en   = hit(paddr, IDX_IRQ_ENA);
   wire sel_hw   = hit(paddr, IDX_HW_STATUS);
   wire sel_any  = sel_fc | sel_rc | sel_sc | sel_st | sel_cl | sel_en | sel_hw;
   wire full_wr  = (pstrb[1:0] == 2'h3);

   // Field decode
   wire [1:0] uv_action = fault_ctrl_ff[ACT_LSB +: 2];
   wire [1:0] ovr_src   = fault_ctrl_ff[SRC_LSB +: 2];
   wire       ovr_vch   = fault_ctrl_ff[VCH_BIT];
   wire [1:0] ovr_beh   = fault_ctrl_ff[OBEH_LSB +: 2];
   wire [2:0] start_slot = run_cfg_ff[SLOT_LSB +: 3];
   wire [1:0] run_beh   = run_cfg_ff[RBEH_LSB +: 2];
   wire [6:0] run_code  = run_cfg_ff[6:0];

   // Synchronised pins: ctrl1, ctrl2, en1, en2
   wire c1 = sync2_ff[0];
   wire c2 = sync2_ff[1];
   wire e1 = sync2_ff[2];
   wire e2 = sync2_ff[3];
   // Edge detect on synchronised undervoltage and high current
   wire uv_rise = ev2_ff[0] && !ev3_ff[0];
   wire hc_rise = ev2_ff[1] && !ev3_ff[1] && fault_ctrl_ff[DET_BIT];

   wire ovr_active = (ovr_src == 2'h1 && c1) || (ovr_src == 2'h2 && c2) ||
                     (ovr_src == 2'h3 && (c1 || c2));
   wire slot_hit = (start_slot != SLOT_NEVER) && (start_slot <= SLOT_LAST)
                   && seq_up && (seq_slot == start_slot);
   // In slot mode only a fresh slot entry re-arms after an undervoltage shut-down
   wire slot_new = slot_hit && !slot_on_ff;
   wire hw_en_mode = (start_slot == SLOT_HWEN1) || (start_slot == SLOT_HWEN2);
   wire hw_en_lvl  = (start_slot == SLOT_HWEN1) ? e1 : e2;
   wire base_on    = hw_en_mode ? hw_en_lvl : slot_on_ff;
   // sleep code applies while override asserted with voltage choice set, run code otherwise
   wire [6:0] pick_code = (ovr_active && ovr_vch) ? sleep_code_ff : run_code;
   // override behaviour, code one disables the converter
   wire ovr_off = ovr_active && (ovr_beh == BEH_AUTO);
   wire [1:0] pick_beh = ovr_active ? ovr_beh : run_beh;
   wire [6:0] sat_code;

   // saturate code to the usable range
   buck2_code_sat u_sat
   (
      .code_in  (pick_code),
      .code_out (sat_code)
   );

   wire [IRQ_W-1:0] irq_set = {hc_rise, uv_rise};
   wire [IRQ_W-1:0] irq_clr = (wr_take && sel_cl) ? pwdata[IRQ_W-1:0]
                                                   : {IRQ_W{1'b0}};
   wire [31:0] rd_mux =
      sel_fc ? {16'h0, fault_ctrl_ff} :
      sel_rc ? {16'h0, run_cfg_ff} :
      sel_sc ? {25'h0, sleep_code_ff} :
      sel_st ? {30'h0, irq_stat_ff} :
      sel_en ? {30'h0, irq_ena_ff} :
      sel_hw ? {25'h0, code_over_ff, ovr_active, conv_enable_ff,
                sync2_ff} : 32'h0;

   // Two-flop synchronisers for all asynchronous pins
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         sync1_ff <= 4'h0;
         sync2_ff <= 4'h0;
         ev1_ff   <= 2'h0;
         ev2_ff   <= 2'h0;
         ev3_ff   <= 2'h0;
      end
      else if (ce)
      begin
         sync1_ff <= {hw_en2, hw_en1, hw_ctrl2, hw_ctrl1};
         sync2_ff <= sync1_ff;
         ev1_ff   <= {high_current, undervolt};
         ev2_ff   <= ev1_ff;
         ev3_ff   <= ev2_ff;
      end
   end

   // APB: no wait state, setup raises pready for the access cycle
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0;
      end
      else if (ce)
      begin
         pready_ff  <= setup;
         pslverr_ff <= setup && !sel_any;
         prdata_ff  <= (setup && !pwrite) ? rd_mux : 32'h0;
      end
   end

   // Configuration registers; otp load sets the upper code bits and clears the low two
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         fault_ctrl_ff <= FAULT_CTRL_RST;
         run_cfg_ff    <= RUN_CFG_RST;
         sleep_code_ff <= 7'h00;
         irq_ena_ff    <= {IRQ_W{1'b0}};
      end
      else if (ce)
      begin
         // upper five bits from configuration, low bits cleared
         if (otp_load)
            run_cfg_ff[6:0] <= {otp_code_hi, 2'h0};
         else if (wr_take && sel_rc && full_wr)
            run_cfg_ff <= pwdata[15:0] & RUN_CFG_WMASK;
         if (wr_take && sel_fc && full_wr)
            fault_ctrl_ff <= pwdata[15:0] & FAULT_CTRL_WMASK;
         if (wr_take && sel_sc && pstrb[0])
            sleep_code_ff <= pwdata[6:0];
         if (wr_take && sel_en && pstrb[0])
            irq_ena_ff <= pwdata[IRQ_W-1:0];
      end
   end

   // sticky status, a new event wins over a clear
   always_ff @(posedge clk)
   begin
      if (srst)
         irq_stat_ff <= {IRQ_W{1'b0}};
      else if (ce)
         irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
   end

   // undervoltage response; off latches until the next slot or pin
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         uv_off_ff  <= 1'b0;
         dev_rst_ff <= 1'b0;
         slot_on_ff <= 1'b0;
      end
      else if (ce)
      begin
         dev_rst_ff <= uv_rise && (uv_action == ACT_RESET);
         if (uv_rise && (uv_action == ACT_OFF))
            uv_off_ff <= 1'b1;
         else if (slot_new || (hw_en_mode && !hw_en_lvl))
            uv_off_ff <= 1'b0;
         if (slot_hit)
            slot_on_ff <= 1'b1;
         else if (start_slot == SLOT_NEVER || !seq_up)
            slot_on_ff <= 1'b0;
      end
   end

   // Registered outputs to the power stage
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         conv_enable_ff <= 1'b0;
         conv_beh_ff    <= BEH_AUTO;
         conv_code_ff   <= VCODE_MIN;
         code_over_ff   <= 1'b0;
         irq_ff         <= 1'b0;
      end
      else if (ce)
      begin
         conv_enable_ff <= base_on && !uv_off_ff && !ovr_off;
         conv_beh_ff    <= pick_beh;
         conv_code_ff   <= sat_code;
         // flag a code beyond the 4MHz limit for software
         code_over_ff   <= freq_4mhz && (pick_code > VCODE_4MHZ);
         irq_ff         <= |(irq_stat_ff & irq_ena_ff);
      end
   end

   assign prdata           = prdata_ff;
   assign pready           = pready_ff;
   assign pslverr          = pslverr_ff;
   assign conv_enable      = conv_enable_ff;
   assign conv_behaviour   = conv_beh_ff;
   assign conv_code        = conv_code_ff;
   // threshold code passed straight to the comparator
   assign hc_threshold     = fault_ctrl_ff[THR_LSB +: 3];
   assign hc_detect_on     = fault_ctrl_ff[DET_BIT];
   assign device_reset_req = dev_rst_ff;
   assign irq              = irq_ff;

   // Assertions
   sequence uv_seen_s;
      ce && uv_rise;
   endsequence

   uv_sticky_a: assert property (@(posedge clk) disable iff (srst)
      uv_seen_s |=> irq_stat_ff[IRQ_UV])
      else $error("undervoltage not recorded");
   uv_reset_a: assert property (@(posedge clk) disable iff (srst)
      uv_seen_s and (uv_action == ACT_RESET) |=> device_reset_req)
      else $error("device reset not requested");
   uv_off_a: assert property (@(posedge clk) disable iff (srst)
      (uv_seen_s and (uv_action == ACT_OFF)) ##1 ce |=> !conv_enable)
      else $error("converter not shut down");
   ovr_code_a: assert property (@(posedge clk) disable iff (srst)
      ce && ovr_active && ovr_vch |=> conv_code == $past(sat_code)
      && $past(pick_code) == $past(sleep_code_ff))
      else $error("override voltage choice wrong");
   ovr_beh_a: assert property (@(posedge clk) disable iff (srst)
      ce && ovr_active && ovr_beh == BEH_AUTO |=> !conv_enable)
      else $error("override disable ignored");
   run_beh_a: assert property (@(posedge clk) disable iff (srst)
      ce && !ovr_active |=> conv_behaviour == $past(run_beh))
      else $error("run behaviour not applied");
   sat_low_a: assert property (@(posedge clk) disable iff (srst)
      conv_code >= VCODE_MIN && conv_code <= VCODE_MAX)
      else $error("code out of range");
   src_none_a: assert property (@(posedge clk) disable iff (srst)
      ovr_src == 2'h0 |-> !ovr_active)
      else $error("override without source");
   hw_en_a: assert property (@(posedge clk) disable iff (srst)
      ce && start_slot == SLOT_HWEN1 && !e1 |=> !conv_enable)
      else $error("hardware enable ignored");
   never_a: assert property (@(posedge clk) disable iff (srst)
      ce && start_slot == SLOT_NEVER && !ovr_active
      ##1 (ce && start_slot == SLOT_NEVER) |=> !conv_enable)
      else $error("enabled with slot zero");
   otp_a: assert property (@(posedge clk) disable iff (srst)
      ce && otp_load |=> run_cfg_ff[1:0] == 2'h0)
      else $error("low code bits not cleared");
   det_a: assert property (@(posedge clk) disable iff (srst)
      !fault_ctrl_ff[DET_BIT] |=> !$rose(irq_stat_ff[IRQ_HC]))
      else $error("detect while disabled");
endmodule // buck2_ctrl
`default_nettype wire

// ==== dv/buck2_stage_model.sv ====
// Model of the power stage and power-up sequencer facing the buck2 block.
// Assumes the bench commands faults and the start of a power-up.
`timescale 1ns/1ps
`default_nettype none
module buck2_stage_model
#(
   parameter int SLOT_CYC = 8
)
(
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       pwr_up,
   input  wire logic       uv_cmd,
   input  wire logic       hc_cmd,
   output logic     [2:0]  seq_slot,
   output logic            seq_up,
   output logic            undervolt,
   output logic            high_current
);
   int cnt_ff;

   // Fault pins follow the bench's commands; they are levels, not pulses
   assign undervolt    = uv_cmd;
   assign high_current = hc_cmd;

   // slots one to five
   // Walks slots one to five, then rests in the last while powered up
   always_ff @(posedge clk)
   begin
      if (srst || !pwr_up)
      begin
         seq_slot <= 3'h0;
         seq_up   <= 1'b0;
         cnt_ff   <= 0;
      end
      else
      begin
         seq_up <= 1'b1;
         cnt_ff <= (cnt_ff == SLOT_CYC - 1) ? 0 : cnt_ff + 1;
         if (seq_slot == 3'h0)
            seq_slot <= 3'h1;
         else if (cnt_ff == SLOT_CYC - 1 && seq_slot < 3'h5)
            seq_slot <= seq_slot + 3'h1;
      end
   end
endmodule // buck2_stage_model
`default_nettype wire

// ==== dv/buck2_ctrl_tb.sv ====
// Self-checking bench for the buck2 control block over APB.
// Assumes one 200 MHz clock and the stage model in buck2_stage_model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
   $display("[ERR] %0t got %h want %h", $time, a, b); end end
module buck2_ctrl_tb;
   import buck2_pkg::*;
   logic        clk, srst, psel, penable, pwrite, otp_load, pwr_up, uv_cmd;
   logic        hw_ctrl1, hw_ctrl2, hw_en1, hw_en2, freq_4mhz, seq_up;
   logic        undervolt, high_current, pready, pslverr, conv_enable;
   logic        hc_detect_on, device_reset_req, irq, ce, hc_cmd;
   logic [31:0] paddr, pwdata, prdata, rng, v;
   logic [3:0]  pstrb;
   logic [4:0]  otp_code_hi;
   logic [2:0]  seq_slot, hc_threshold;
   logic [1:0]  conv_behaviour, src;
   logic [6:0]  conv_code, rc;
   logic [15:0] rv;
   logic [32:0] expq[$];
   logic [32:0] exp_v;
   int          bad_count, check_count, rst_pulses, n;

   buck2_ctrl i_buck2_ctrl (.clk, .srst, .ce, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .otp_load,
      .otp_code_hi, .seq_slot, .seq_up, .hw_ctrl1, .hw_ctrl2, .hw_en1,
      .hw_en2, .undervolt, .high_current, .freq_4mhz, .conv_enable,
      .conv_behaviour, .conv_code, .hc_threshold, .hc_detect_on,
      .device_reset_req, .irq);
   buck2_stage_model i_buck2_stage_model (.clk, .srst, .pwr_up, .uv_cmd,
      .hc_cmd, .seq_slot, .seq_up, .undervolt, .high_current);

   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   // Applied code never leaves the 08h..68h span
   function automatic logic [6:0] sat(input logic [6:0] c);
      return (c < VCODE_MIN) ? VCODE_MIN : (c > VCODE_MAX) ? VCODE_MAX : c;
   endfunction

   // One APB transfer; a read notes its expected {pslverr, prdata}
   task automatic apb(input logic w, input logic [15:0] idx,
                      input logic [31:0] d, input logic [32:0] e);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {14'h0, idx, 2'h0};
      pwdata  <= d;
      if (!w)
         expq.push_back(e);
      @(posedge clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the answer
      do
         @(posedge clk);
      while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      // Idle edge keeps a following call from re-raising psel at once
      @(posedge clk);
   endtask
   task automatic wr(input logic [15:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d, 33'h0);
   endtask
   task automatic rd(input logic [15:0] idx, input logic [31:0] e);
      apb(1'b0, idx, 32'h0, {1'b0, e});
   endtask
   // Pins pass two synchronisers plus a register; six cycles covers it
   task automatic settle();
      repeat (6) @(posedge clk);
   endtask
   task automatic wait_slot(input logic [2:0] s);
      for (n = 0; n < 200 && seq_slot !== s; n++) @(posedge clk);
   endtask
   task automatic uv_pulse();
      uv_cmd <= 1'b1;
      repeat (4) @(posedge clk);
      uv_cmd <= 1'b0;
      settle();
   endtask
   task automatic wrap_up();
      if (bad_count == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Read answers are taken oldest first as they complete
   always @(posedge clk)
      if (psel && penable && pready === 1'b1 && !pwrite)
      begin
         // Pop once; the macro reads its arguments twice
         exp_v = expq.pop_front();
         `CHK({pslverr, prdata}, exp_v)
      end
   // Count device reset pulses, which stand one cycle only
   always @(posedge clk)
      if (device_reset_req === 1'b1)
         rst_pulses++;

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Hang guard, far beyond the expected run of several hundred cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      wrap_up();
   end

   initial
   begin
      {psel, penable, pwrite, otp_load, pwr_up, uv_cmd} = '0;
      {hw_ctrl1, hw_ctrl2, hw_en1, hw_en2, paddr, pwdata} = '0;
      {ce, hc_cmd} = 2'h2;
      // kept at 2MHz so any run code stays legal
      freq_4mhz = 1'b0;
      pstrb = 4'hF;
      otp_code_hi = 5'h00;
      rng = 32'd90581;
      srst = 1'b1;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd(IDX_FAULT_CTRL, {16'h0, FAULT_CTRL_RST});
      rd(IDX_RUN_CFG, {16'h0, RUN_CFG_RST});
      `CHK(conv_behaviour, BEH_AUTO)
      `CHK(hc_detect_on, 1'b0)
      `CHK(conv_enable, 1'b0)
      apb(1'b0, 16'h4070, 32'h0, {1'b1, 32'h0});
      // Every threshold code, with random neighbours in the register
      for (int i = 0; i < 8; i++)
      begin
         v = xs();
         v[6:4] = i[2:0];
         wr(IDX_FAULT_CTRL, v);
         rd(IDX_FAULT_CTRL, {16'h0, v[15:0] & FAULT_CTRL_WMASK});
         `CHK(hc_threshold, i[2:0])
         `CHK(hc_detect_on, v[0])
      end
      wr(IDX_FAULT_CTRL, 32'h0);
      wr(IDX_RUN_CFG, {16'h0, SLOT_HWEN1, 13'h0});
      hw_en1 <= 1'b1;
      settle();
      `CHK(conv_enable, 1'b1)
      // Clock enable low freezes the pin path and the output
      ce <= 1'b0;
      hw_en1 <= 1'b0;
      settle();
      `CHK(conv_enable, 1'b1)
      ce <= 1'b1;
      settle();
      `CHK(conv_enable, 1'b0)
      wr(IDX_RUN_CFG, {16'h0, SLOT_HWEN2, 13'h0});
      hw_en1 <= 1'b1;
      settle();
      `CHK(conv_enable, 1'b0)
      hw_en2 <= 1'b1;
      settle();
      `CHK(conv_enable, 1'b1)
      // Code boundaries and every run behaviour; last code has low bits set
      for (int i = 0; i < 8; i++)
      begin
         rc = (i == 7) ? 7'h7F : (i == 6) ? 7'h68 : 7'h04 + 7'(i * 20);
         rv = {SLOT_HWEN2, 3'h0, 2'(i), 1'b0, rc};
         wr(IDX_RUN_CFG, {16'h0, rv});
         settle();
         `CHK(conv_code, sat(rc))
         `CHK(conv_behaviour, 2'(i))
      end
      v = xs();
      otp_code_hi <= v[4:0];
      otp_load <= 1'b1;
      @(posedge clk);
      otp_load <= 1'b0;
      settle();
      rv = {rv[15:7], v[4:0], 2'h0};
      rd(IDX_RUN_CFG, {16'h0, rv});
      rc = sat(rv[6:0]);
      wr(IDX_SLEEP_CODE, 32'h30);
      // Each source against each single override pin
      for (int i = 0; i < 8; i++)
      begin
         src = i[2:1];
         wr(IDX_FAULT_CTRL, {16'h0, 3'h0, src, 1'b1, BEH_FCCM, 8'h0});
         hw_ctrl1 <= !i[0];
         hw_ctrl2 <= i[0];
         settle();
         n = src[i[0]];
         `CHK(conv_code, n ? 7'h30 : rc)
         `CHK(conv_behaviour, n ? BEH_FCCM : 2'h3)
      end
      wr(IDX_FAULT_CTRL, {16'h0, 3'h0, 2'h3, 1'b0, BEH_AUTO, 8'h0});
      settle();
      `CHK(conv_code, rc)
      `CHK(conv_enable, 1'b0)
      {hw_ctrl1, hw_ctrl2} <= 2'h0;
      settle();
      `CHK(conv_enable, 1'b1)
      // Power-up sequencing: nothing before the last slot, never at code 0
      hw_en2 <= 1'b0;
      wr(IDX_RUN_CFG, {16'h0, SLOT_LAST, 13'h0});
      pwr_up <= 1'b1;
      wait_slot(3'h4);
      settle();
      `CHK(conv_enable, 1'b0)
      wait_slot(3'h5);
      settle();
      `CHK(conv_enable, 1'b1)
      // Undervolt: ignore, then shut off, then device reset
      wr(IDX_IRQ_ENA, 32'h1);
      wr(IDX_FAULT_CTRL, {16'h0, ACT_IGNORE, 14'h0});
      uv_pulse();
      rd(IDX_IRQ_STAT, 32'h1);
      `CHK(irq, 1'b1)
      `CHK(conv_enable, 1'b1)
      wr(IDX_IRQ_CLR, 32'h1);
      settle();
      `CHK(irq, 1'b0)
      wr(IDX_FAULT_CTRL, {16'h0, ACT_OFF, 14'h0});
      uv_pulse();
      `CHK(conv_enable, 1'b0)
      wr(IDX_IRQ_ENA, 32'h0);
      settle();
      `CHK(irq, 1'b0)
      rd(IDX_IRQ_STAT, 32'h1);
      wr(IDX_IRQ_CLR, 32'h1);
      rst_pulses = 0;
      wr(IDX_FAULT_CTRL, {16'h0, ACT_RESET, 14'h0});
      uv_pulse();
      `CHK(rst_pulses, 1)
      // High current: no event while detection is off, one once it is on
      wr(IDX_IRQ_CLR, 32'h3);
      wr(IDX_FAULT_CTRL, 32'h0);
      hc_cmd <= 1'b1;
      settle();
      hc_cmd <= 1'b0;
      rd(IDX_IRQ_STAT, 32'h0);
      wr(IDX_FAULT_CTRL, 32'h1);
      hc_cmd <= 1'b1;
      settle();
      hc_cmd <= 1'b0;
      rd(IDX_IRQ_STAT, 32'h2);
      pwr_up <= 1'b0;
      wr(IDX_RUN_CFG, 32'h0);
      pwr_up <= 1'b1;
      wait_slot(3'h5);
      settle();
      `CHK(conv_enable, 1'b0)
      wrap_up();
   end
endmodule // buck2_ctrl_tb
`default_nettype wire
